// ### tb/scal_front_end.sv
`timescale 1ns/1ps
// ****
// sensor front end and analog stage model
// ****
module scal_front_end (
    input  wire       core_clk,
    output reg  [9:0] temp_meas,
    output reg        temp_meas_valid,
    output reg  [9:0] signal_meas,
    output reg        signal_meas_valid,
    output reg  [9:0] instrument_amp_signal,
    output reg  [9:0] gain_stage_signal,
    output reg  [9:0] voltage_output_signal,
    output reg  [9:0] aux_pin_one_level,
    output reg  [9:0] aux_pin_two_level
);
    initial
    begin
        {temp_meas, temp_meas_valid, signal_meas, signal_meas_valid} = '0;
        set_src(4'h0, 10'h000);
    end
    // one-cycle reading strobe
    task send_meas(input is_sig, input [9:0] v);
    begin
        @(posedge core_clk);
        #1;
        if (is_sig)
            {signal_meas, signal_meas_valid} = {v, 1'b1};
        else
            {temp_meas, temp_meas_valid} = {v, 1'b1};
        @(posedge core_clk);
        #1;
        {signal_meas_valid, temp_meas_valid} = 2'b00;
    end
    endtask
    // other sources carry the inverse
    task set_src(input [3:0] code, input [9:0] v);
    begin
        gain_stage_signal = (code == 4'h0) ? v : ~v;
        instrument_amp_signal = (code == 4'h6) ? v : ~v;
        voltage_output_signal = (code == 4'h3) ? v : ~v;
        aux_pin_one_level = (code == 4'h4) ? v : ~v;
        aux_pin_two_level = (code == 4'h5) ? v : ~v;
    end
    endtask
endmodule

// ### tb/scal_top_asserts.sv
`timescale 1ns/1ps
// ****
// port checks of the compensation block
// ****
module scal_top_asserts (
    input wire       core_clk,
    input wire       rst_n,
    input wire [7:0] cfg_mode_byte,
    input wire [7:0] cfg_gain_trim_lo,
    input wire [7:0] cfg_offset_trim_lo,
    input wire [7:0] cfg_trim_hi_byte,
    input wire [3:0] cfg_filter_factor,
    input wire [7:0] segment_count_byte,
    input wire [7:0] alarm_low_limit,
    input wire [7:0] alarm_low_level,
    input wire [7:0] alarm_high_limit,
    input wire [7:0] alarm_high_level,
    input wire [7:0] alarm_ctrl_byte,
    input wire [7:0] steer_ctrl_byte,
    input wire [7:0] steer_level1,
    input wire [7:0] steer_level2,
    input wire [7:0] steer_level3,
    input wire [9:0] temp_meas,
    input wire       temp_meas_valid,
    input wire [9:0] gain_stage_signal,
    input wire [9:0] gain_dac_code,
    input wire [9:0] offset_dac_code,
    input wire [9:0] filtered_temp,
    input wire [9:0] output_code,
    input wire       alarm_low,
    input wire       alarm_high,
    input wire       aux_pin_one_out,
    input wire       aux_pin_one_oe_n,
    input wire       aux_pin_two_out,
    input wire       aux_pin_two_oe_n
);
    wire [7:0] src = gain_stage_signal[9:2];
    wire [3:0] fac = (cfg_filter_factor > 4'h6) ? 4'h6 : cfg_filter_factor;
    wire [1:0] lvl_cnt = {1'b0, steer_level1 <= src} + {1'b0, steer_level2 <= src} + {1'b0, steer_level3 <= src};
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    sequence s_alarm_gain;
        cfg_mode_byte[5] && !cfg_mode_byte[4] && alarm_ctrl_byte[7:4] == 4'h0;
    endsequence
    sequence s_steer_gain;
        cfg_mode_byte[4] && steer_ctrl_byte[7:4] == 4'h0;
    endsequence
    a_fixed_trim: assert property (segment_count_byte[3:0] == 4'h0 |=>
        gain_dac_code == $past({cfg_trim_hi_byte[1:0], cfg_gain_trim_lo})
        && offset_dac_code == $past({cfg_trim_hi_byte[3:2], cfg_offset_trim_lo}))
        else $error("trim code wrong");
    a_filter_up: assert property (temp_meas_valid && temp_meas > filtered_temp |=>
        filtered_temp == $past(filtered_temp + ((temp_meas - filtered_temp) >> fac)))
        else $error("filter step wrong");
    a_filter_hold: assert property (!temp_meas_valid |=> $stable(filtered_temp))
        else $error("filter moved");
    a_alarm_low: assert property (s_alarm_gain ##0 src < alarm_low_limit |=>
        alarm_low && output_code == {$past(alarm_low_level), 2'b00})
        else $error("low alarm wrong");
    a_alarm_high: assert property (s_alarm_gain ##0 src > alarm_high_limit && src >= alarm_low_limit |=>
        alarm_high && output_code == {$past(alarm_high_level), 2'b00})
        else $error("high alarm wrong");
    a_mode_excl: assert property (cfg_mode_byte[4] |=> !alarm_low && !alarm_high)
        else $error("alarm during steering");
    a_steer_oe: assert property (rst_n |=> aux_pin_one_oe_n == !$past(cfg_mode_byte[4])
        && aux_pin_two_oe_n == aux_pin_one_oe_n)
        else $error("aux enable wrong");
    a_steer_level: assert property (s_steer_gain |=> {aux_pin_two_out, aux_pin_one_out} == $past(lvl_cnt))
        else $error("aux level wrong");
endmodule

bind scal_top scal_top_asserts u_scal_top_asserts (.*);

// ### tb/tb_scal_top.sv
`timescale 1ns/1ps
// ****
// scenarios for the compensation block
// ****
module tb_scal_top;
    reg         core_clk = 1'b0;
    reg         rst_n = 1'b0;
    reg  [7:0]  cfg_mode_byte, cfg_coarse_byte, cfg_gain_trim_lo, cfg_offset_trim_lo, cfg_trim_hi_byte;
    reg  [7:0]  segment_count_byte, alarm_low_limit, alarm_low_level, alarm_high_limit, alarm_high_level;
    reg  [7:0]  alarm_ctrl_byte, steer_ctrl_byte, steer_level1, steer_level2, steer_level3;
    reg  [3:0]  cfg_filter_factor, c;
    reg  [29:0] temp_breakpoints;
    reg  [47:0] gain_temp_coeff, offset_temp_coeff;
    reg  [31:0] signal_breakpoint_hi, signal_breakpoint_lo;
    reg  [59:0] signal_slope_coeff;
    reg  [49:0] signal_ordinate;
    reg  [23:0] seg_codes = 24'hfeca86;
    reg  [23:0] src_codes = 24'h260345;
    wire [9:0]  temp_meas, signal_meas, instrument_amp_signal, gain_stage_signal, voltage_output_signal;
    wire [9:0]  aux_pin_one_level, aux_pin_two_level, gain_dac_code, offset_dac_code, filtered_temp, output_code;
    wire        temp_meas_valid, signal_meas_valid, output_digital, alarm_low, alarm_high;
    wire        aux_pin_one_out, aux_pin_one_oe_n, aux_pin_two_out, aux_pin_two_oe_n;
    wire [2:0]  coarse_gain_sel, signal_segment;
    wire [4:0]  coarse_offset_sel;
    wire [1:0]  temp_gap;
    integer     n_mismatch = 0;
    integer     checks_done = 0;
    integer     i;
    always #50 core_clk = ~core_clk;
    scal_top #(.TC_SHIFT(4)) u_scal_top (.*);
    scal_front_end u_scal_front_end (.*);
    task chk(input string nm, input [9:0] seen, input [9:0] exp);
    begin
        checks_done += 1;
        if (seen !== exp)
        begin
            n_mismatch += 1;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
        end
    end
    endtask
    task tick(input integer n);
    begin
        repeat (n) @(posedge core_clk);
        #1;
    end
    endtask
    task conclude;
    begin
        if (n_mismatch == 0 && checks_done > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    end
    endtask
    task t_trim;
    begin
        {cfg_mode_byte, cfg_coarse_byte} = 16'h01fd;
        {cfg_trim_hi_byte, cfg_gain_trim_lo, cfg_offset_trim_lo} = 24'h052cf4;
        tick(3);
        chk("gain", gain_dac_code, 10'h12c);
        chk("cgain", coarse_gain_sel, 10'h001);
        chk("coff", coarse_offset_sel, 10'h01f);
        {cfg_mode_byte, cfg_gain_trim_lo} = 16'h052d;
        tick(3);
        chk("cgain", coarse_gain_sel, 10'h005);
        chk("gain", gain_dac_code, 10'h12d);
    end
    endtask
    task t_filt(input [3:0] f, input [9:0] m, input [9:0] e);
    begin
        cfg_filter_factor = f;
        u_scal_front_end.send_meas(1'b0, m);
        tick(2);
        chk("filt", filtered_temp, e);
    end
    endtask
    task t_gap;
    begin
        segment_count_byte = 8'hf5;
        temp_breakpoints = {10'h384, 10'h258, 10'h064};
        {gain_temp_coeff, offset_temp_coeff} = {48'h010808, 48'h810008};
        tick(4);
        chk("gap", temp_gap, 10'h001);
        chk("gain", gain_dac_code, 10'h1ab);
        chk("offset", offset_dac_code, 10'h176);
        t_filt(4'h0, 10'h032, 10'h032);
        tick(3);
        chk("gap", temp_gap, 10'h000);
        chk("gain", gain_dac_code, 10'h146);
        chk("offset", offset_dac_code, 10'h1db);
    end
    endtask
    task t_segcnt;
    begin
        cfg_mode_byte = 8'h40;
        {signal_breakpoint_hi, signal_breakpoint_lo} = 64'h02010100_00800080;
        for (i = 0; i < 6; i = i + 1)
        begin
            segment_count_byte = {seg_codes[23 - 4 * i -: 4], 4'h0};
            u_scal_front_end.send_meas(1'b1, 10'h3fc);
            tick(4);
            chk("seg", signal_segment, (i == 0) ? 10'h000 : i[9:0] - 10'h001);
        end
    end
    endtask
    task t_sig(input [9:0] m, input [9:0] e);
    begin
        u_scal_front_end.send_meas(1'b1, m);
        tick(4);
        chk("out", output_code, e);
        chk("dig", output_digital, cfg_mode_byte[6]);
    end
    endtask
    task t_correct;
    begin
        segment_count_byte = 8'hc5;
        {signal_slope_coeff, signal_ordinate} = {60'ha00400, 50'h60010};
        t_sig(10'h040, 10'h050);
        t_sig(10'h300, 10'h040);
        cfg_mode_byte = 8'h00;
        t_sig(10'h300, 10'h300);
    end
    endtask
    task t_alarm;
    begin
        {alarm_low_limit, alarm_low_level, alarm_high_limit, alarm_high_level} = 32'h4011c0ee;
        cfg_mode_byte = 8'h20;
        for (i = 0; i < 6; i = i + 1)
        begin
            c = src_codes[23 - 4 * i -: 4];
            alarm_ctrl_byte = {c, 4'h0};
            u_scal_front_end.set_src(c, 10'h000);
            tick(2);
            chk("alo", alarm_low, 10'h001);
            chk("out", output_code, 10'h044);
            u_scal_front_end.set_src(c, 10'h3fc);
            tick(2);
            chk("ahi", alarm_high, {9'h000, c != 4'h2});
            chk("out", output_code, (c == 4'h2) ? 10'h044 : 10'h3b8);
        end
        cfg_mode_byte = 8'h30;
        tick(2);
        chk("alo", alarm_low, 10'h000);
    end
    endtask
    task t_steer;
    begin
        {steer_ctrl_byte, steer_level1, steer_level2, steer_level3} = 32'h004080c0;
        cfg_mode_byte = 8'h10;
        for (i = 0; i < 4; i = i + 1)
        begin
            u_scal_front_end.set_src(4'h0, {i[1:0], 8'h00});
            tick(2);
            chk("aux", {aux_pin_two_out, aux_pin_one_out}, i[9:0]);
            chk("oe_n", {aux_pin_two_oe_n, aux_pin_one_oe_n}, 10'h000);
        end
        cfg_mode_byte = 8'h00;
        tick(2);
        chk("oe_n", {aux_pin_two_oe_n, aux_pin_one_oe_n}, 10'h003);
    end
    endtask
    initial
    begin
        // alarm and steering bytes start cleared while unused
        {alarm_low_limit, alarm_low_level, alarm_high_limit, alarm_high_level, alarm_ctrl_byte, steer_ctrl_byte,
         steer_level1, steer_level2, steer_level3} = '0;
        segment_count_byte = 8'hf0;
        tick(6);
        rst_n = 1'b1;
        t_trim;
        t_filt(4'h0, 10'h0c8, 10'h0c8);
        t_filt(4'h2, 10'h12c, 10'h0e1);
        t_filt(4'h9, 10'h121, 10'h0e2);
        t_gap;
        t_segcnt;
        t_correct;
        t_alarm;
        t_steer;
        conclude;
    end
    initial
    begin
        repeat (3000) @(posedge core_clk);
        n_mismatch += 1;
        conclude;
    end
endmodule

// ### verilog/scal_defines.vh
`ifndef SCAL_DEFINES_VH
`define SCAL_DEFINES_VH

// ****************************************
// mode byte field positions
// ****************************************
`define SCAL_MODE_DIGITAL_BIT 6
`define SCAL_MODE_ALARM_BIT   5
`define SCAL_MODE_STEER_BIT   4
`define SCAL_MODE_VOUT_BIT    2
`define SCAL_MODE_IOUT_BIT    0

// ****************************************
// coarse byte and shared trim byte fields
// ****************************************
`define SCAL_COARSE_GAIN_SEL_MSB     2
`define SCAL_COARSE_OFFSET_SEL_MSB     7
`define SCAL_COARSE_OFFSET_SEL_LSB     3
`define SCAL_GN_HI_LSB    0
`define SCAL_OF_HI_LSB    2

// ****************************************
// segment count byte codes
// ****************************************
`define SCAL_SEG_FIXED    4'hf
`define SCAL_SEG_ONE      4'he
`define SCAL_SEG_TWO      4'hc
`define SCAL_SEG_THREE    4'ha
`define SCAL_SEG_FOUR     4'h8
`define SCAL_SEG_FIVE     4'h6
`define SCAL_GAP_FIXED    4'h0
`define SCAL_GAP_TWO      4'h5
`define SCAL_GAP_THREE    4'h8
`define SCAL_GAP_FOUR     4'hb

// ****************************************
// alarm and steering source codes
// ****************************************
`define SCAL_SRC_TEMP     4'h2
`define SCAL_SRC_IAMP     4'h6
`define SCAL_SRC_GAIN     4'h0
`define SCAL_SRC_VOUT     4'h3
`define SCAL_SRC_AUX1     4'h4
`define SCAL_SRC_AUX2     4'h5

// ****************************************
// arithmetic constants and reset values
// ****************************************
`define SCAL_FILTER_MAX   4'h6
`define SCAL_TC_SHIFT     8
`define SCAL_PC_FRAC_BITS 10
`define SCAL_CODE_MAX     10'h3ff
`define SCAL_RST_CODE     10'h000

`endif

// ### verilog/scal_gap_calc.v
`timescale 1ns/1ps
`include "scal_defines.vh"

// ****************************************
// one dac code from trim and per-gap coefficients
// ****************************************
module scal_gap_calc #(
    parameter TC_SHIFT = `SCAL_TC_SHIFT
) (
    input  wire        core_clk,
    input  wire        rst_n,
    input  wire        tc_enable,
    input  wire [9:0]  trim,
    input  wire [47:0] coeff,
    input  wire [29:0] breakpoints,
    input  wire [9:0]  temp,
    input  wire [1:0]  gap,
    output wire [9:0]  code
);
    reg  [9:0]         code_ff;
    wire [39:0]        bp_ext;
    wire signed [23:0] psum [0:4];
    reg  [9:0]         nxt_code;

    // top entry only pads the last gap, it is never a lower bound
    assign bp_ext  = {`SCAL_CODE_MAX, breakpoints};
    assign psum[0] = {14'h0000, trim};

    genvar k;
    generate
        for (k = 0; k < 4; k = k + 1)
        begin : g_gap
            wire [10:0]        mag;
            wire               up;
            wire [9:0]         lo;
            wire [9:0]         hi;
            wire [9:0]         d;
            wire [20:0]        prod;
            wire [20:0]        scaled;
            wire signed [23:0] term;
            assign mag = coeff[12*k+10 -: 11];
            // first gap counts down from its upper breakpoint, so its sign is flipped
            assign up  = (k == 0) ? coeff[12*k+11] : ~coeff[12*k+11];
            if (k == 0)
            begin : g_first
                assign lo = 10'h000;
                assign hi = bp_ext[9:0];
                assign d  = (gap == 2'h0) ? (hi - temp) : 10'h000;
            end
            else
            begin : g_next
                assign lo = bp_ext[10*k-1 -: 10];
                assign hi = bp_ext[10*k+9 -: 10];
                assign d  = (gap > k) ? (hi - lo) :
                            (gap == k) ? (temp - lo) : 10'h000;
            end
            assign prod   = mag * d;
            assign scaled = prod >> TC_SHIFT;
            assign term   = up ? $signed({3'h0, scaled}) : -$signed({3'h0, scaled});
            assign psum[k+1] = psum[k] + term;
        end
    endgenerate

    always @*
    begin
        if (!tc_enable)
            nxt_code = trim;
        else if (psum[4] < 0)
            nxt_code = 10'h000;
        else if (psum[4] > $signed({14'h0000, `SCAL_CODE_MAX}))
            nxt_code = `SCAL_CODE_MAX;
        else
            nxt_code = psum[4][9:0];
    end

    // recomputed on every edge with no trigger
    always @(posedge core_clk)
    begin
        if (!rst_n)
            code_ff <= `SCAL_RST_CODE;
        else
            code_ff <= nxt_code;
    end

    assign code = code_ff;
endmodule

// ### verilog/scal_top.v
`timescale 1ns/1ps
`include "scal_defines.vh"

module scal_top #(
    parameter TC_SHIFT = `SCAL_TC_SHIFT
) (
    input  wire        core_clk,
    input  wire        rst_n,
    input  wire [7:0]  cfg_mode_byte,
    input  wire [7:0]  cfg_coarse_byte,
    input  wire [7:0]  cfg_gain_trim_lo,
    input  wire [7:0]  cfg_offset_trim_lo,
    input  wire [7:0]  cfg_trim_hi_byte,
    input  wire [3:0]  cfg_filter_factor,
    input  wire [7:0]  segment_count_byte,
    input  wire [29:0] temp_breakpoints,
    input  wire [47:0] gain_temp_coeff,
    input  wire [47:0] offset_temp_coeff,
    input  wire [31:0] signal_breakpoint_hi,
    input  wire [31:0] signal_breakpoint_lo,
    input  wire [59:0] signal_slope_coeff,
    input  wire [49:0] signal_ordinate,
    input  wire [7:0]  alarm_low_limit,
    input  wire [7:0]  alarm_low_level,
    input  wire [7:0]  alarm_high_limit,
    input  wire [7:0]  alarm_high_level,
    input  wire [7:0]  alarm_ctrl_byte,
    input  wire [7:0]  steer_ctrl_byte,
    input  wire [7:0]  steer_level1,
    input  wire [7:0]  steer_level2,
    input  wire [7:0]  steer_level3,
    input  wire [9:0]  temp_meas,
    input  wire        temp_meas_valid,
    input  wire [9:0]  signal_meas,
    input  wire        signal_meas_valid,
    input  wire [9:0]  instrument_amp_signal,
    input  wire [9:0]  gain_stage_signal,
    input  wire [9:0]  voltage_output_signal,
    input  wire [9:0]  aux_pin_one_level,
    input  wire [9:0]  aux_pin_two_level,
    output wire [9:0]  gain_dac_code,
    output wire [9:0]  offset_dac_code,
    output wire [2:0]  coarse_gain_sel,
    output wire [4:0]  coarse_offset_sel,
    output wire [9:0]  filtered_temp,
    output wire [1:0]  temp_gap,
    output wire [2:0]  signal_segment,
    output wire [9:0]  output_code,
    output wire        output_digital,
    output wire        alarm_low,
    output wire        alarm_high,
    output wire        aux_pin_one_out,
    output wire        aux_pin_one_oe_n,
    output wire        aux_pin_two_out,
    output wire        aux_pin_two_oe_n
);
    // ****************************************
    // state
    // ****************************************
    reg  [9:0]  filt_ff;
    reg  [1:0]  gap_ff;
    reg  [9:0]  sig_ff;
    reg  [2:0]  seg_ff;
    reg  [2:0]  coarse_gain_sel_ff;
    reg  [4:0]  coarse_offset_sel_ff;
    reg  [9:0]  out_ff;
    reg         digital_ff;
    reg         alarm_low_ff;
    reg         alarm_high_ff;
    reg  [1:0]  steer_ff;
    reg         steer_oe_n_ff;

    reg  [9:0]  nxt_filt;
    reg  [2:0]  ngap;
    reg  [2:0]  nseg;
    reg         seg_fixed;
    reg  [2:0]  seg_cap;
    reg  [9:0]  seg_base;
    reg  [9:0]  nxt_out;
    reg  [9:0]  corrected;
    reg  [9:0]  alarm_src;
    reg  [9:0]  steer_src;

    wire        digital_mode;
    wire        alarm_on;
    wire        steer_on;
    wire        current_only;
    wire [9:0]  gain_trim;
    wire [9:0]  offset_trim;
    wire [3:0]  filter_n;
    wire [10:0] filt_diff;
    wire [9:0]  filt_step_up;
    wire [9:0]  filt_step_dn;
    wire [1:0]  nxt_gap;
    wire [3:0]  above;
    wire [2:0]  nxt_seg;
    wire [11:0] slope;
    wire [9:0]  ordinate;
    wire [9:0]  seg_diff;
    wire [20:0] seg_prod;
    wire [10:0] seg_scaled;
    wire signed [12:0] seg_sum;
    wire        nxt_alarm_low;
    wire        nxt_alarm_high;
    wire [1:0]  nxt_steer;

    // ****************************************
    // mode decode
    // ****************************************
    assign digital_mode = cfg_mode_byte[`SCAL_MODE_DIGITAL_BIT];
    // steering wins so the shared comparator is never claimed twice
    assign steer_on     = cfg_mode_byte[`SCAL_MODE_STEER_BIT];
    assign alarm_on     = cfg_mode_byte[`SCAL_MODE_ALARM_BIT] & ~steer_on;
    assign current_only = cfg_mode_byte[`SCAL_MODE_IOUT_BIT] & ~cfg_mode_byte[`SCAL_MODE_VOUT_BIT];

    // ****************************************
    // trims
    // ****************************************
    assign gain_trim   = {cfg_trim_hi_byte[`SCAL_GN_HI_LSB+1:`SCAL_GN_HI_LSB], cfg_gain_trim_lo};
    assign offset_trim = {cfg_trim_hi_byte[`SCAL_OF_HI_LSB+1:`SCAL_OF_HI_LSB], cfg_offset_trim_lo};

    // ****************************************
    // temperature filter
    // ****************************************
    assign filter_n     = (cfg_filter_factor > `SCAL_FILTER_MAX) ? `SCAL_FILTER_MAX : cfg_filter_factor;
    assign filt_diff    = {1'b0, temp_meas} - {1'b0, filt_ff};
    assign filt_step_up = filt_diff[9:0] >> filter_n;
    assign filt_step_dn = (filt_ff - temp_meas) >> filter_n;

    always @*
    begin
        nxt_filt = filt_ff;
        if (temp_meas_valid)
        begin
            if (temp_meas > filt_ff)
                nxt_filt = filt_ff + filt_step_up;
            else
                nxt_filt = filt_ff - filt_step_dn;
        end
    end

    // ****************************************
    // gap and segment count decode
    // ****************************************
    always @*
    begin
        case (segment_count_byte[3:0])
            `SCAL_GAP_TWO:   ngap = 3'h2;
            `SCAL_GAP_THREE: ngap = 3'h3;
            `SCAL_GAP_FOUR:  ngap = 3'h4;
            default:         ngap = 3'h1;
        endcase
        seg_fixed = 1'b0;
        case (segment_count_byte[7:4])
            `SCAL_SEG_ONE:   nseg = 3'h1;
            `SCAL_SEG_TWO:   nseg = 3'h2;
            `SCAL_SEG_THREE: nseg = 3'h3;
            `SCAL_SEG_FOUR:  nseg = 3'h4;
            `SCAL_SEG_FIVE:  nseg = 3'h5;
            default:
            begin
                nseg      = 3'h1;
                seg_fixed = 1'b1;
            end
        endcase
        // shared coefficient storage caps segments by gap count
        case (ngap)
            3'h2:    seg_cap = 3'h3;
            3'h3:    seg_cap = 3'h2;
            3'h4:    seg_cap = 3'h0;
            default: seg_cap = 3'h5;
        endcase
        if (seg_cap == 3'h0)
            seg_fixed = 1'b1;
        else if (nseg > seg_cap)
            nseg = seg_cap;
    end

    // ****************************************
    // temperature gap select
    // ****************************************
    assign nxt_gap = {1'b0, (filt_ff >= temp_breakpoints[9:0]) && (ngap >= 3'h2)} +
                     {1'b0, (filt_ff >= temp_breakpoints[19:10]) && (ngap >= 3'h3)} +
                     {1'b0, (filt_ff >= temp_breakpoints[29:20]) && (ngap >= 3'h4)};

    // ****************************************
    // gain and offset codes
    // ****************************************
    scal_gap_calc #(
        .TC_SHIFT (TC_SHIFT)
    ) u_gain (
        .core_clk    (core_clk),
        .rst_n       (rst_n),
        .tc_enable   (ngap != 3'h1),
        .trim        (gain_trim),
        .coeff       (gain_temp_coeff),
        .breakpoints (temp_breakpoints),
        .temp        (filt_ff),
        .gap         (gap_ff),
        .code        (gain_dac_code)
    );

    scal_gap_calc #(
        .TC_SHIFT (TC_SHIFT)
    ) u_offset (
        .core_clk    (core_clk),
        .rst_n       (rst_n),
        .tc_enable   (ngap != 3'h1),
        .trim        (offset_trim),
        .coeff       (offset_temp_coeff),
        .breakpoints (temp_breakpoints),
        .temp        (filt_ff),
        .gap         (gap_ff),
        .code        (offset_dac_code)
    );

    // ****************************************
    // signal segment select
    // ****************************************
    genvar j;
    generate
        for (j = 0; j < 4; j = j + 1)
        begin : g_seg
            wire [9:0] bp;
            assign bp       = {signal_breakpoint_hi[8*j+1:8*j], signal_breakpoint_lo[8*j+7:8*j]};
            assign above[j] = (j < nseg - 3'h1) && (sig_ff >= bp);
        end
    endgenerate

    assign nxt_seg = {2'h0, above[0]} + {2'h0, above[1]} + {2'h0, above[2]} + {2'h0, above[3]};

    always @*
    begin
        case (seg_ff)
            3'h1:    seg_base = {signal_breakpoint_hi[1:0], signal_breakpoint_lo[7:0]};
            3'h2:    seg_base = {signal_breakpoint_hi[9:8], signal_breakpoint_lo[15:8]};
            3'h3:    seg_base = {signal_breakpoint_hi[17:16], signal_breakpoint_lo[23:16]};
            3'h4:    seg_base = {signal_breakpoint_hi[25:24], signal_breakpoint_lo[31:24]};
            default: seg_base = 10'h000;
        endcase
    end

    // ****************************************
    // signal correction
    // ****************************************
    assign slope      = signal_slope_coeff[seg_ff*12 +: 12];
    assign ordinate   = signal_ordinate[seg_ff*10 +: 10];
    assign seg_diff   = (sig_ff > seg_base) ? (sig_ff - seg_base) : 10'h000;
    assign seg_prod   = seg_diff * slope[10:0];
    assign seg_scaled = seg_prod[`SCAL_PC_FRAC_BITS+10:`SCAL_PC_FRAC_BITS];
    assign seg_sum    = slope[11] ? $signed({3'h0, ordinate}) - $signed({2'h0, seg_scaled})
                                  : $signed({3'h0, ordinate}) + $signed({2'h0, seg_scaled});

    always @*
    begin
        if (seg_fixed)
            corrected = sig_ff;
        else if (seg_sum < 0)
            corrected = 10'h000;
        else if (seg_sum > $signed({3'h0, `SCAL_CODE_MAX}))
            corrected = `SCAL_CODE_MAX;
        else
            corrected = seg_sum[9:0];
    end

    // ****************************************
    // alarm and steering sources
    // ****************************************
    always @*
    begin
        case (alarm_ctrl_byte[7:4])
            `SCAL_SRC_TEMP: alarm_src = filt_ff;
            `SCAL_SRC_IAMP: alarm_src = instrument_amp_signal;
            `SCAL_SRC_VOUT: alarm_src = voltage_output_signal;
            `SCAL_SRC_AUX1: alarm_src = aux_pin_one_level;
            `SCAL_SRC_AUX2: alarm_src = aux_pin_two_level;
            default:        alarm_src = gain_stage_signal;
        endcase
        case (steer_ctrl_byte[7:4])
            `SCAL_SRC_TEMP: steer_src = filt_ff;
            `SCAL_SRC_IAMP: steer_src = instrument_amp_signal;
            `SCAL_SRC_VOUT: steer_src = voltage_output_signal;
            default:        steer_src = gain_stage_signal;
        endcase
    end

    // all-zero alarm bytes never trip the low side; the enable bit guards the high side
    assign nxt_alarm_low  = alarm_on && (alarm_src[9:2] < alarm_low_limit);
    assign nxt_alarm_high = alarm_on && (alarm_src[9:2] > alarm_high_limit);
    assign nxt_steer      = {1'b0, steer_src[9:2] >= steer_level1} + {1'b0, steer_src[9:2] >= steer_level2} +
                            {1'b0, steer_src[9:2] >= steer_level3};

    // ****************************************
    // output select
    // ****************************************
    always @*
    begin
        if (nxt_alarm_low)
            nxt_out = {alarm_low_level, 2'h0};
        else if (nxt_alarm_high)
            nxt_out = {alarm_high_level, 2'h0};
        else if (digital_mode)
            nxt_out = corrected;
        else
            nxt_out = sig_ff;
    end

    // ****************************************
    // registers
    // ****************************************
    always @(posedge core_clk)
    begin
        if (!rst_n)
        begin
            filt_ff       <= `SCAL_RST_CODE;
            gap_ff        <= 2'h0;
            sig_ff        <= `SCAL_RST_CODE;
            seg_ff        <= 3'h0;
            coarse_gain_sel_ff       <= 3'h0;
            coarse_offset_sel_ff       <= 5'h00;
            out_ff        <= `SCAL_RST_CODE;
            digital_ff    <= 1'b0;
            alarm_low_ff  <= 1'b0;
            alarm_high_ff <= 1'b0;
            steer_ff      <= 2'h0;
            steer_oe_n_ff <= 1'b1;
        end
        else
        begin
            filt_ff       <= nxt_filt;
            gap_ff        <= nxt_gap;
            if (signal_meas_valid)
                sig_ff <= signal_meas;
            seg_ff        <= seg_fixed ? 3'h0 : nxt_seg;
            // current output has only two coarse gain bits
            coarse_gain_sel_ff       <= {cfg_coarse_byte[`SCAL_COARSE_GAIN_SEL_MSB] & ~current_only,
                              cfg_coarse_byte[`SCAL_COARSE_GAIN_SEL_MSB-1:0]};
            coarse_offset_sel_ff       <= cfg_coarse_byte[`SCAL_COARSE_OFFSET_SEL_MSB:`SCAL_COARSE_OFFSET_SEL_LSB];
            out_ff        <= nxt_out;
            digital_ff    <= digital_mode | nxt_alarm_low | nxt_alarm_high;
            alarm_low_ff  <= nxt_alarm_low;
            alarm_high_ff <= nxt_alarm_high;
            steer_ff      <= steer_on ? nxt_steer : 2'h0;
            steer_oe_n_ff <= ~steer_on;
        end
    end

    // ****************************************
    // outputs
    // ****************************************
    assign coarse_gain_sel   = coarse_gain_sel_ff;
    assign coarse_offset_sel = coarse_offset_sel_ff;
    assign filtered_temp     = filt_ff;
    assign temp_gap          = gap_ff;
    assign signal_segment    = seg_ff;
    assign output_code       = out_ff;
    assign output_digital    = digital_ff;
    assign alarm_low         = alarm_low_ff;
    assign alarm_high        = alarm_high_ff;
    assign aux_pin_one_out   = steer_ff[0];
    assign aux_pin_two_out   = steer_ff[1];
    // pins float as analog inputs unless steering drives them
    assign aux_pin_one_oe_n  = steer_oe_n_ff;
    assign aux_pin_two_oe_n  = steer_oe_n_ff;
endmodule
